// [core/flash_modify_signature_control.sv]
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module flash_modify_signature_control
   import flash_sig_pkg::*;
#(
   parameter int BLOCKS     = 6,
   parameter int PAGE_COUNT = 16,
   parameter int HV_CYCLES  = 64
)(
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // Register port.
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [31:0]       reg_rdata_o,
   // Array read path.
   input  wire logic              arr_rd_i,
   output logic                   arr_rd_invalid_o,
   // Interlock writes into the array space.
   input  wire logic              il_wr_i,
   input  wire logic              il_word_i,
   input  wire logic [19:0]       il_addr_i,
   input  wire logic [31:0]       il_data_i,
   // Page stream from the array macro during a check.
   output logic                   page_req_o,
   input  wire logic              page_valid_i,
   input  wire logic [127:0]      page_data_i,
   input  wire logic [15:0]       page_ecc_i,
   input  wire logic [1:0]        page_sed_i,
   input  wire logic [1:0]        page_ded_i,
   // Controls toward the array macro.
   output logic                   hv_active_o,
   output logic                   erase_mode_o,
   output logic [BLOCKS-1:0]      erase_blocks_o,
   output logic [19:0]            prog_addr_o,
   output logic [63:0]            prog_data_o,
   output logic                   margin_read_o,
   output logic                   margin_level_o,
   output logic                   ecc_force_o,
   output logic [63:0]            forced_data_o,
   output logic [7:0]             forced_syn_o
);

   localparam int PC_W = $clog2(PAGE_COUNT + 1);
   localparam int HV_W = $clog2(HV_CYCLES + 1);
   localparam logic [PC_W-1:0] PAGE_LAST = PC_W'(PAGE_COUNT - 1);
   localparam logic [HV_W-1:0] HV_LAST   = HV_W'(HV_CYCLES - 1);

   seq_state_t           state_reg;       // Sequencer state.
   logic                 pgm_reg;         // Program selected.
   logic                 ers_reg;         // Erase selected.
   logic                 hv_reg;          // High-voltage start bit.
   logic                 done_reg;        // Operation done flag.
   logic                 pass_reg;        // Pass flag.
   logic                 rwe_reg;         // Read-while-write error.
   logic                 il_seen_reg;     // Interlock write taken.
   logic                 aie_reg;         // Integrity start bit.
   logic                 aid_reg;         // Integrity done flag.
   logic                 mre_reg;         // Margin read enable.
   logic                 mrv_reg;         // Margin level select.
   logic                 eie_reg;         // ECC check enable.
   logic [7:0]           syn_reg;         // Forced syndrome.
   logic [31:0]          ut1_reg;         // Forced low word.
   logic [31:0]          ut2_reg;         // Forced high word.
   logic [BLOCKS-1:0]    bsr_reg;         // Block select register.
   logic [PC_W-1:0]      page_cnt_reg;    // Pages taken so far.
   logic [HV_W-1:0]      hv_cnt_reg;      // High-voltage cycles.
   logic [SIG_W-1:0]     sig_q;           // Whole signature word.
   logic [SIG_W-1:0]     sig_in;          // Page mapped to the word.
   logic [SIG_W-1:0]     sig_rot;         // Signature rotated by one place.
   logic                 acc_ok;          // Test registers reachable.
   logic                 op_lock;         // Operands frozen.
   logic                 active;          // Voltage phase or check scan in progress.
   logic                 sig_step;        // One page accumulated.
   logic                 wr_mcr;          // Write to control.
   logic                 wr_ut0;          // Write to test 0.
   logic                 hv_go;           // Accepted high-voltage start.
   logic                 aie_go;          // Accepted integrity start.

   // Decode and gating terms shared by the processes below.
   always_comb begin
      acc_ok   = done_reg & aid_reg;
      op_lock  = (hv_reg & ~done_reg) | (aie_reg & ~aid_reg);
      active   = (state_reg != ST_IDLE);
      sig_step = (state_reg == ST_SCAN) & page_valid_i;
      wr_mcr   = reg_wr_i & (reg_addr_i == OFS_MCR);
      wr_ut0   = reg_wr_i & (reg_addr_i == OFS_UT0);
      // Start only with exactly one of program or erase selected and an
      // interlock taken; the integrity start bit must be clear.
      hv_go    = wr_mcr & reg_wdata_i[MCR_HV] & ~hv_reg & (pgm_reg ^ ers_reg)
                 & il_seen_reg & ~aie_reg;
      // The integrity start is refused while program, erase or voltage
      // are selected.
      aie_go   = wr_ut0 & reg_wdata_i[UT0_AIE] & ~aie_reg
                 & ~pgm_reg & ~ers_reg & ~hv_reg;
   end

   // Select and start bits of the control register.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         // Reset drops all selects, so the array comes back in read mode.
         pgm_reg <= 1'b0;
         ers_reg <= 1'b0;
         hv_reg  <= 1'b0;
      end else if (wr_mcr) begin
         // Selects cannot move while high voltage is on.
         if (!hv_reg) begin
            pgm_reg <= reg_wdata_i[MCR_PGM];
            ers_reg <= reg_wdata_i[MCR_ERS];
         end
         if (hv_go) begin
            hv_reg <= 1'b1;
         end else if (!reg_wdata_i[MCR_HV]) begin
            hv_reg <= 1'b0;
         end
      end
   end

   // Interlock capture: the first write latches address, every write in program mode data.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         il_seen_reg <= 1'b0;
         prog_addr_o <= 20'h0_0000;
         prog_data_o <= 64'hFFFF_FFFF_FFFF_FFFF;
      end else if (wr_mcr && !hv_reg && !reg_wdata_i[MCR_PGM]
                   && !reg_wdata_i[MCR_ERS]) begin
         // Dropping the select cancels what was prepared.
         il_seen_reg <= 1'b0;
         prog_data_o <= 64'hFFFF_FFFF_FFFF_FFFF;
      end else if (il_wr_i && (pgm_reg || ers_reg) && !op_lock) begin
         // The operands arrive after selection and before start.
         if (!il_seen_reg) begin
            prog_addr_o <= il_addr_i;
         end
         il_seen_reg <= 1'b1;
         if (pgm_reg) begin
            if (il_word_i) begin
               prog_data_o[63:32] <= il_data_i;
            end else begin
               prog_data_o[31:0]  <= il_data_i;
            end
         end
      end
   end

   // Test register 0 selects plus the forced ECC operands.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mre_reg <= 1'b0;
         mrv_reg <= 1'b0;
         eie_reg <= 1'b0;
         syn_reg <= 8'h00;
         ut1_reg <= ZERO_WORD;
         ut2_reg <= ZERO_WORD;
      end else if (acc_ok && !op_lock) begin
         // Guarded bits ignore writes while a done flag is low.
         if (wr_ut0) begin
            mre_reg <= reg_wdata_i[UT0_MRE];
            mrv_reg <= reg_wdata_i[UT0_MRV];
            eie_reg <= reg_wdata_i[UT0_EIE];
            syn_reg <= reg_wdata_i[UT0_SYN_LO +: SYN_W];
         end
         if (reg_wr_i && reg_addr_i == OFS_UT1) begin
            ut1_reg <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == OFS_UT2) begin
            ut2_reg <= reg_wdata_i;
         end
      end
   end

   // Block select: frozen while a started operation runs.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bsr_reg <= '0;
      end else if (reg_wr_i && reg_addr_i == OFS_BSR && !op_lock) begin
         bsr_reg <= reg_wdata_i[BLOCKS-1:0];
      end
   end

   // Sequencer for the voltage phase and the page scan of a check.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         // Any running operation ends here; its region is not reliable.
         state_reg    <= ST_IDLE;
         aie_reg      <= 1'b0;
         aid_reg      <= 1'b1;
         done_reg     <= 1'b1;
         pass_reg     <= 1'b1;
         page_cnt_reg <= '0;
         hv_cnt_reg   <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (hv_go) begin
                  state_reg  <= ST_HV;
                  done_reg   <= 1'b0;
                  hv_cnt_reg <= '0;
               end else if (aie_go) begin
                  // Check, margin read and ECC test share this start.
                  state_reg    <= ST_SCAN;
                  aie_reg      <= 1'b1;
                  aid_reg      <= 1'b0;
                  page_cnt_reg <= '0;
               end else if (wr_ut0 && !reg_wdata_i[UT0_AIE]) begin
                  aie_reg <= 1'b0;
               end
            end
            ST_HV: begin
               if (wr_mcr && !reg_wdata_i[MCR_HV]) begin
                  // Clearing voltage early aborts and fails the operation.
                  state_reg <= ST_IDLE;
                  done_reg  <= 1'b1;
                  pass_reg  <= 1'b0;
               end else if (hv_cnt_reg == HV_LAST) begin
                  state_reg <= ST_IDLE;
                  done_reg  <= 1'b1;
                  pass_reg  <= 1'b1;
               end else begin
                  hv_cnt_reg <= hv_cnt_reg + 1'b1;
               end
            end
            ST_SCAN: begin
               if (wr_ut0 && !reg_wdata_i[UT0_AIE]) begin
                  // Withdrawing the start ends the scan early.
                  state_reg <= ST_IDLE;
                  aie_reg   <= 1'b0;
                  aid_reg   <= 1'b1;
               end else if (page_valid_i) begin
                  if (page_cnt_reg == PAGE_LAST) begin
                     state_reg <= ST_IDLE;
                     aid_reg   <= 1'b1;
                  end else begin
                     page_cnt_reg <= page_cnt_reg + 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Read-while-write error: hardware set wins over a software clear.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rwe_reg <= 1'b0;
      end else if (arr_rd_i && active) begin
         rwe_reg <= 1'b1;
      end else if (wr_mcr && reg_wdata_i[MCR_RWE]) begin
         rwe_reg <= 1'b0;
      end
   end

   // One bank only, so every array read during a modify is invalid.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         arr_rd_invalid_o <= 1'b0;
      end else begin
         arr_rd_invalid_o <= arr_rd_i & active;
      end
   end

   // Map one page onto the 160-bit input word.
   always_comb begin
      sig_in                            = '0;
      sig_in[127:0]                     = page_data_i;
      sig_in[128+E_EVEN_LO +: ECC_W]    = page_ecc_i[7:0];
      sig_in[128+E_EVEN_SED]            = page_sed_i[0];
      sig_in[128+E_EVEN_DED]            = page_ded_i[0];
      sig_in[128+E_ODD_LO +: ECC_W]     = page_ecc_i[15:8];
      sig_in[128+E_ODD_SED]             = page_sed_i[1];
      sig_in[128+E_ODD_DED]             = page_ded_i[1];
   end

   // Rotate by one so each slice finds its shift-in bit at its own base,
   // which keeps every index in range for the first slice as well.
   assign sig_rot = {sig_q[SIG_W-2:0], sig_q[SIG_W-1]};

   // Five slices chained into one shift path, top bit fed back.
   for (genvar i = 0; i < SIG_SLICES; i++) begin : g_sig
      sig_slice u_slice (
         .clk_sys_i (clk_sys_i),
         .rst_i     (rst_i),
         .load_i    (reg_wr_i & acc_ok
                     & (reg_addr_i == OFS_SIG0 + 8'(4 * i))),
         .seed_i    (reg_wdata_i),
         .step_i    (sig_step),
         .data_i    (sig_in[i*DATA_W +: DATA_W]),
         .shift_i   (sig_rot[i*DATA_W]),
         .fb_i      (sig_q[SIG_W-1]),
         .value_o   (sig_q[i*DATA_W +: DATA_W])
      );
   end

   // Read data, one cycle after the strobe; unmapped words read zero.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= ZERO_WORD;
      end else if (reg_rd_i) begin
         reg_rdata_o <= ZERO_WORD;
         if (reg_addr_i == OFS_MCR) begin
            reg_rdata_o[MCR_HV]   <= hv_reg;
            reg_rdata_o[MCR_ERS]  <= ers_reg;
            reg_rdata_o[MCR_PGM]  <= pgm_reg;
            reg_rdata_o[MCR_PASS] <= pass_reg;
            reg_rdata_o[MCR_DONE] <= done_reg;
            reg_rdata_o[MCR_RWE]  <= rwe_reg;
         end else if (reg_addr_i == OFS_BSR) begin
            reg_rdata_o[BLOCKS-1:0] <= bsr_reg;
         end else if (reg_addr_i == OFS_UT0) begin
            reg_rdata_o[UT0_AID] <= aid_reg;
            reg_rdata_o[UT0_AIE] <= aie_reg;
            // Guarded bits read zero while inaccessible.
            if (acc_ok) begin
               reg_rdata_o[UT0_EIE] <= eie_reg;
               reg_rdata_o[UT0_MRV] <= mrv_reg;
               reg_rdata_o[UT0_MRE] <= mre_reg;
               reg_rdata_o[UT0_SYN_LO +: SYN_W] <= syn_reg;
            end
         end else if (acc_ok && reg_addr_i == OFS_UT1) begin
            reg_rdata_o <= ut1_reg;
         end else if (acc_ok && reg_addr_i == OFS_UT2) begin
            reg_rdata_o <= ut2_reg;
         end else if (acc_ok && reg_addr_i >= OFS_SIG0 && reg_addr_i <= OFS_SIG4
                      && reg_addr_i[1:0] == 2'b00) begin
            // Signature words are only meaningful once both flags are up.
            reg_rdata_o <= sig_q[(reg_addr_i - OFS_SIG0) * 8 +: DATA_W];
         end
      end
   end

   // Controls toward the array macro.
   assign page_req_o     = state_reg[1];
   assign hv_active_o    = state_reg[2];
   assign erase_mode_o   = ers_reg;
   assign erase_blocks_o = bsr_reg;
   assign margin_read_o  = mre_reg;
   assign margin_level_o = mrv_reg;
   assign ecc_force_o    = eie_reg;
   assign forced_data_o  = {ut2_reg, ut1_reg};
   assign forced_syn_o   = syn_reg;

   // Accepted integrity start and a finishing last page.
   sequence seq_check_start;
      wr_ut0 && reg_wdata_i[UT0_AIE] && !aie_reg && !pgm_reg && !ers_reg
      && !hv_reg && state_reg == ST_IDLE;
   endsequence

   sequence seq_last_page;
      state_reg == ST_SCAN && page_valid_i && page_cnt_reg == PAGE_LAST
      && !wr_ut0;
   endsequence

   AST_RWE_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      arr_rd_i && active |=> rwe_reg)
      else $error("read during modify did not flag error");

   AST_RD_INVALID: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      arr_rd_i && active |=> arr_rd_invalid_o)
      else $error("read during modify not marked invalid");

   AST_SIG_GUARD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_SIG0 && !acc_ok && !sig_step
      |=> $stable(sig_q[31:0]))
      else $error("signature written while inaccessible");

   AST_SEED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == OFS_SIG0 && acc_ok
      |=> sig_q[31:0] == $past(reg_wdata_i))
      else $error("signature seed not loaded");

   AST_AID_CLR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      seq_check_start |=> !aid_reg && aie_reg && page_req_o)
      else $error("integrity start did not clear done");

   AST_AID_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      seq_last_page |=> aid_reg && !page_req_o)
      else $error("integrity done not set after last page");

   AST_AIE_GUARD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(aie_reg) |-> !$past(pgm_reg) && !$past(ers_reg) && !$past(hv_reg))
      else $error("integrity start taken with program path busy");

   AST_BSR_LOCK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      op_lock && reg_wr_i && reg_addr_i == OFS_BSR |=> $stable(bsr_reg))
      else $error("block select changed while started");

   AST_HV_START: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(hv_reg) |-> !done_reg && hv_active_o && $past(il_seen_reg))
      else $error("voltage start without interlock or done");

   AST_CANCEL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      wr_mcr && !hv_reg && !reg_wdata_i[MCR_PGM] && !reg_wdata_i[MCR_ERS]
      |=> !il_seen_reg)
      else $error("deselect did not cancel operation");

endmodule

// [core/flash_sig_pkg.sv]
package flash_sig_pkg;

   // Register bus geometry.
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 8;

   // Register byte offsets, one aligned word each.
   localparam logic [7:0]  OFS_MCR     = 8'h00;
   localparam logic [7:0]  OFS_BSR     = 8'h04;
   localparam logic [7:0]  OFS_UT0     = 8'h08;
   localparam logic [7:0]  OFS_UT1     = 8'h0C;
   localparam logic [7:0]  OFS_UT2     = 8'h10;
   localparam logic [7:0]  OFS_SIG0    = 8'h14;
   localparam logic [7:0]  OFS_SIG4    = 8'h24;

   // Main control register fields.
   localparam int          MCR_HV      = 0;
   localparam int          MCR_ERS     = 2;
   localparam int          MCR_PGM     = 4;
   localparam int          MCR_PASS    = 9;
   localparam int          MCR_DONE    = 10;
   localparam int          MCR_RWE     = 14;

   // User test register 0 fields.
   localparam int          UT0_AID     = 0;
   localparam int          UT0_AIE     = 1;
   localparam int          UT0_EIE     = 3;
   localparam int          UT0_MRV     = 4;
   localparam int          UT0_MRE     = 5;
   localparam int          UT0_SYN_LO  = 16;
   localparam int          SYN_W       = 8;

   // Signature word: five slices of 32 bits.
   localparam int          SIG_SLICES  = 5;
   localparam int          SIG_W       = SIG_SLICES * DATA_W;
   localparam int          ECC_W       = 8;

   // Placement inside the ECC slice.
   localparam int          E_EVEN_LO   = 0;
   localparam int          E_EVEN_SED  = 10;
   localparam int          E_EVEN_DED  = 11;
   localparam int          E_ODD_LO    = 16;
   localparam int          E_ODD_SED   = 26;
   localparam int          E_ODD_DED   = 27;

   // Feedback taps applied to every slice when the top bit is set.
   localparam logic [31:0] SIG_TAPS    = 32'h0000_0007;

   // Reset values.
   localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

   // Sequencer states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SCAN  = 3'b010,
      ST_HV    = 3'b100
   } seq_state_t;

endpackage

// [core/sig_slice.sv]
`timescale 1ns/1ps

// One 32-bit slice of the multiple-input signature shift register.
module sig_slice
   import flash_sig_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // Seed load from software.
   input  wire logic              load_i,
   input  wire logic [31:0]       seed_i,
   // Accumulation step.
   input  wire logic              step_i,
   input  wire logic [31:0]       data_i,
   input  wire logic              shift_i,
   input  wire logic              fb_i,
   // Current value.
   output logic      [31:0]       value_o
);

   // A seed write wins over a step; the parent offers loads only while both done flags are up.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         value_o <= ZERO_WORD;
      end else if (load_i) begin
         value_o <= seed_i;
      end else if (step_i) begin
         // Shift one place, fold in the input word and the feedback taps.
         value_o <= {value_o[30:0], shift_i} ^ data_i ^ (SIG_TAPS & {32{fb_i}});
      end
   end

endmodule

// [testbench/test_flash_modify_signature_control.sv]
`timescale 1ns/1ps

// Register-level bench: seeds, scan signature model, read-while-write and program abort.
module test_flash_modify_signature_control;
   import flash_sig_pkg::*;
   logic         clk_sys_i = 0, rst_i = 1, wr = 0, rd = 0, arr = 0, ilw = 0, pv = 0;
   logic [7:0]   ad = 0;
   logic [31:0]  wd = 0, rdat, lf = 32'hF017CCFD;
   logic [127:0] pd = 0;
   logic [15:0]  pe = 0;
   logic [1:0]   ps = 0, pdd = 0;
   logic         inv, preq, hv, ilh = 0, mro, mlo, efo, emo;
   logic [19:0]  ia = 0, pao;
   logic [5:0]   ebo;
   logic [7:0]   fso;
   logic [63:0]  pdo, fdo;
   logic [159:0] m = 0, d;
   int           err_count = 0, n_compared = 0;

   flash_modify_signature_control #(.PAGE_COUNT(4), .HV_CYCLES(4)) i_dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(ad), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .arr_rd_i(arr),
      .arr_rd_invalid_o(inv), .il_wr_i(ilw), .il_word_i(ilh), .il_addr_i(ia),
      .il_data_i(wd), .page_req_o(preq), .page_valid_i(pv), .page_data_i(pd),
      .page_ecc_i(pe), .page_sed_i(ps), .page_ded_i(pdd), .hv_active_o(hv),
      .erase_mode_o(emo), .erase_blocks_o(ebo), .prog_addr_o(pao), .prog_data_o(pdo),
      .margin_read_o(mro), .margin_level_o(mlo), .ecc_force_o(efo), .forced_data_o(fdo),
      .forced_syn_o(fso));

   // Free-running 25 MHz clock.
   initial forever #20 clk_sys_i = ~clk_sys_i;

   // Next value of the stimulus shift register.
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Reference signature step: shift each slice, fold data, feed back the top bit.
   function automatic logic [159:0] sg(input logic [159:0] q, input logic [159:0] x);
      logic [159:0] r;
      for (int i = 0; i < 5; i++) begin
         r[32*i+:32] = {q[32*i+:31], (i == 0) ? q[159] : q[32*i-1]}
                       ^ x[32*i+:32] ^ (SIG_TAPS & {32{q[159]}});
      end
      return r;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys_i) begin ad <= a; wd <= v; wr <= 1; end
      @(posedge clk_sys_i) wr <= 0;
   endtask

   // Read strobe for one cycle; data is looked at in the following cycle only.
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys_i) begin ad <= a; rd <= 1; end
      @(posedge clk_sys_i) rd <= 0;
      @(negedge clk_sys_i) chk(rdat, e);
   endtask

   // One array read attempt, one cycle long.
   task automatic pulse();
      @(posedge clk_sys_i) arr <= 1;
      @(posedge clk_sys_i) arr <= 0;
   endtask

   // Interlock write into the array space: word select, address and data.
   task automatic ilwr(input logic h, input logic [19:0] a, input logic [31:0] v);
      @(posedge clk_sys_i) begin ilh <= h; ia <= a; wd <= v; ilw <= 1; end
      @(posedge clk_sys_i) ilw <= 0;
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under 1000 cycles.
   initial begin
      #200us;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 0;
      rchk(OFS_MCR, 32'h600);
      rchk(8'h30, 0);
      for (int i = 0; i < 5; i++) begin
         lf = nx(lf);
         m[32*i+:32] = lf;
         wreg(OFS_SIG0 + 8'(4*i), lf);
      end
      for (int i = 0; i < 5; i++) rchk(OFS_SIG0 + 8'(4*i), m[32*i+:32]);
      $display("seed test done");
      wreg(OFS_UT0, 32'h2);
      @(negedge clk_sys_i) chk(32'(preq), 1);
      rchk(OFS_SIG0, 0);
      wreg(OFS_SIG0, 32'hFFFFFFFF);
      wreg(OFS_BSR, 32'h3F);
      pulse();
      @(negedge clk_sys_i) chk(32'(inv), 1);
      for (int p = 0; p < 4; p++) begin
         lf = nx(lf);
         d = {4'h0, lf[19], lf[17], 2'b0, lf[15:8], 4'h0, lf[18], lf[16], 2'b0, lf[7:0],
              lf, ~lf, lf ^ 32'h5A5A5A5A, nx(lf)};
         m = sg(m, d);
         @(posedge clk_sys_i) begin
            pd <= d[127:0]; pe <= lf[15:0]; ps <= lf[17:16]; pdd <= lf[19:18]; pv <= 1;
         end
         @(posedge clk_sys_i) pv <= 0;
      end
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i) chk(32'(preq), 0);
      chk(32'(ebo), 0);
      rchk(OFS_UT0, 32'h3);
      rchk(OFS_MCR, 32'h4600);
      for (int i = 0; i < 5; i++) rchk(OFS_SIG0 + 8'(4*i), m[32*i+:32]);
      pulse();
      @(negedge clk_sys_i) chk(32'(inv), 0);
      wreg(OFS_UT0, 0);
      wreg(OFS_MCR, 32'h4000);
      $display("scan test done");
      wreg(OFS_MCR, 32'h10);
      ilwr(1'b0, lf[19:0], lf);
      ilwr(1'b1, 20'h00000, ~lf);
      wreg(OFS_MCR, 32'h11);
      @(negedge clk_sys_i) chk(32'(hv), 1);
      chk(32'(pao), 32'(lf[19:0]));
      chk(pdo[31:0], lf);
      chk(pdo[63:32], ~lf);
      wreg(OFS_UT0, 32'h2);
      @(negedge clk_sys_i) chk(32'(preq), 0);
      wreg(OFS_MCR, 32'h10);
      rchk(OFS_MCR, 32'h410);
      wreg(OFS_MCR, 0);
      $display("program test done");
      lf = nx(lf);
      wreg(OFS_UT0, 32'h00AB0038);
      wreg(OFS_UT1, lf);
      wreg(OFS_UT2, ~lf);
      wreg(OFS_BSR, lf);
      @(negedge clk_sys_i) chk(32'(mro), 1);
      chk(32'(mlo), 1);
      chk(32'(efo), 1);
      chk(32'(fso), 32'hAB);
      chk(fdo[31:0], lf);
      chk(fdo[63:32], ~lf);
      chk(32'(ebo), 32'(lf[5:0]));
      wreg(OFS_UT0, 32'h20);
      @(negedge clk_sys_i) chk(32'(mlo), 0);
      $display("operand test done");
      wreg(OFS_MCR, 32'h4);
      ilwr(1'b0, 20'h00000, 32'h0);
      wreg(OFS_MCR, 32'h5);
      @(negedge clk_sys_i) chk(32'(hv), 1);
      chk(32'(emo), 1);
      @(posedge clk_sys_i) rst_i <= 1;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 0;
      @(negedge clk_sys_i) chk(32'(hv), 0);
      chk(32'(emo), 0);
      rchk(OFS_MCR, 32'h600);
      rchk(OFS_BSR, 0);
      $display("reset test done");
      close_out();
   end
endmodule
